// ===== rtl/bwu_pkg.sv
// Purpose: Shared constants of the bridge window upper register bank
// Assumes: Register offsets are byte addresses on a 32-bit word port
// Notes:   Field positions and fixed read values are defined here; the assertions and the bench repeat them as literals
package bwu_pkg;

	localparam logic [7:0]  BWU_OFF_PF_TOP_LOW  = 8'h24;
	localparam logic [7:0]  BWU_OFF_PF_BOT_HIGH = 8'h28;
	localparam logic [7:0]  BWU_OFF_PF_TOP_HIGH = 8'h2c;
	localparam logic [7:0]  BWU_OFF_IO_HIGH     = 8'h30;
	localparam logic [7:0]  BWU_OFF_CAP_PTR     = 8'h34;
	localparam logic [7:0]  BWU_OFF_INT_PIN     = 8'h3c;

	localparam int          BWU_PF_LIM_LSB      = 20;
	localparam int          BWU_PF_LIM_W        = 12;
	localparam int          BWU_PF_CAP_LSB      = 16;
	localparam int          BWU_IO_TOP_LSB      = 16;
	localparam int          BWU_INT_PIN_LSB     = 8;

	localparam logic [3:0]  BWU_PF_ADDR_CAP     = 4'h1;
	localparam logic [7:0]  BWU_CAP_PTR_VAL     = 8'hdc;
	localparam logic [7:0]  BWU_INT_PIN_VAL     = 8'h00;
	localparam logic [19:0] BWU_LOW_ONES        = 20'hfffff;
	localparam logic [19:0] BWU_LOW_ZERO        = 20'h00000;

	localparam logic [11:0] BWU_RST_PF_TOP_LOW  = 12'h000;
	localparam logic [31:0] BWU_RST_WORD        = 32'h00000000;
	localparam logic [15:0] BWU_RST_IO_HALF     = 16'h0000;

endpackage

// ===== rtl/bwu_rd_mux.sv
// Purpose: Registered read-back of the window register words
// Assumes: Read strobe is one cycle; data stand the following cycle only
// Notes:   Unmapped offsets and unowned bits read as zero
`timescale 1ns/1ns
`default_nettype none
module bwu_rd_mux
	import bwu_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        rd,
	input  wire logic [7:0]  addr,
	input  wire logic [11:0] pf_top_low,
	input  wire logic [31:0] pf_bot_high,
	input  wire logic [31:0] pf_top_high,
	input  wire logic [15:0] io_bot_high,
	input  wire logic [15:0] io_top_high,
	output logic      [31:0] rdata
);

	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h00000000;
		if (rd) begin
			case (addr)
				BWU_OFF_PF_TOP_LOW: begin
					next_rdata[BWU_PF_LIM_LSB +: BWU_PF_LIM_W] = pf_top_low;
					next_rdata[BWU_PF_CAP_LSB +: 4] = BWU_PF_ADDR_CAP;
				end
				BWU_OFF_PF_BOT_HIGH: begin
					next_rdata = pf_bot_high;
				end
				BWU_OFF_PF_TOP_HIGH: begin
					next_rdata = pf_top_high;
				end
				BWU_OFF_IO_HIGH: begin
					next_rdata = {io_top_high, io_bot_high};
				end
				BWU_OFF_CAP_PTR: begin
					next_rdata[7:0] = BWU_CAP_PTR_VAL;
				end
				BWU_OFF_INT_PIN: begin
					next_rdata[BWU_INT_PIN_LSB +: 8] = BWU_INT_PIN_VAL;
				end
				default: begin
					next_rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdata <= 32'h00000000;
		end else begin
			rdata <= next_rdata;
		end
	end

endmodule
`default_nettype wire

// ===== rtl/bwu_top.sv
// Purpose: Upper window registers of a two-port bridge and prefetch decode
// Assumes: Full-word writes; the prefetch base [31:20] comes from outside
// Notes:   Bounds are re-registered before decode, adding one cycle
`timescale 1ns/1ns
`default_nettype none
module bwu_top
	import bwu_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [11:0] pf_base_low,
	input  wire logic [63:0] mem_addr,
	input  wire logic        mem_addr_valid,
	output logic             pf_hit,
	output logic             pf_hit_valid,
	output logic      [63:0] pf_base_full,
	output logic      [63:0] pf_limit_full,
	output logic      [15:0] io_bottom_high,
	output logic      [15:0] io_top_high
);

	logic [11:0] pf_top_low;
	logic [31:0] pf_bot_high;
	logic [31:0] pf_top_high;
	logic        wr_top_low;
	logic        wr_bot_high;
	logic        wr_top_high;
	logic        wr_io;

	bwu_win_if win ();

	assign wr_top_low  = reg_wr && (reg_addr == BWU_OFF_PF_TOP_LOW);
	assign wr_bot_high = reg_wr && (reg_addr == BWU_OFF_PF_BOT_HIGH);
	assign wr_top_high = reg_wr && (reg_addr == BWU_OFF_PF_TOP_HIGH);
	assign wr_io       = reg_wr && (reg_addr == BWU_OFF_IO_HIGH);

	// Only bits 31:20 are stored; the capability nibble is a constant
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pf_top_low <= BWU_RST_PF_TOP_LOW;
		end else if (wr_top_low) begin
			pf_top_low <= reg_wdata[BWU_PF_LIM_LSB +: BWU_PF_LIM_W];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pf_bot_high <= BWU_RST_WORD;
		end else if (wr_bot_high) begin
			pf_bot_high <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pf_top_high <= BWU_RST_WORD;
		end else if (wr_top_high) begin
			pf_top_high <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			io_bottom_high <= BWU_RST_IO_HALF;
			io_top_high    <= BWU_RST_IO_HALF;
		end else if (wr_io) begin
			io_bottom_high <= reg_wdata[15:0];
			io_top_high    <= reg_wdata[BWU_IO_TOP_LSB +: 16];
		end
	end

	// Extra register stage keeps the 64-bit compare off the bus path
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pf_limit_full <= {BWU_RST_WORD, BWU_RST_PF_TOP_LOW, BWU_LOW_ONES};
		end else begin
			pf_limit_full <= {pf_top_high, pf_top_low, BWU_LOW_ONES};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pf_base_full <= {BWU_RST_WORD, BWU_RST_PF_TOP_LOW, BWU_LOW_ZERO};
		end else begin
			pf_base_full <= {pf_bot_high, pf_base_low, BWU_LOW_ZERO};
		end
	end

	assign win.base  = pf_base_full;
	assign win.limit = pf_limit_full;
	assign win.addr  = mem_addr;
	assign win.req   = mem_addr_valid;
	assign pf_hit       = win.hit;
	assign pf_hit_valid = win.hit_vld;

	bwu_window_cmp u_cmp (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.win     (win)
	);

	bwu_rd_mux u_rd (
		.clk_sys     (clk_sys),
		.sys_rst     (sys_rst),
		.rd          (reg_rd),
		.addr        (reg_addr),
		.pf_top_low  (pf_top_low),
		.pf_bot_high (pf_bot_high),
		.pf_top_high (pf_top_high),
		.io_bot_high (io_bottom_high),
		.io_top_high (io_top_high),
		.rdata       (reg_rdata)
	);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence s_wr(logic [7:0] off);
		reg_wr && (reg_addr == off);
	endsequence

	sequence s_rd(logic [7:0] off);
		reg_rd && (reg_addr == off);
	endsequence

	property p_cap_field;
		s_rd(BWU_OFF_PF_TOP_LOW) |=> (reg_rdata[19:16] == 4'h1);
	endproperty
	a_cap_field: assert property (p_cap_field)
		else $error("addressing capability field not 0001");

	property p_top_low_back;
		s_wr(BWU_OFF_PF_TOP_LOW) ##1 s_rd(BWU_OFF_PF_TOP_LOW)
			|=> (reg_rdata[31:20] == $past(reg_wdata[31:20], 2));
	endproperty
	a_top_low_back: assert property (p_top_low_back)
		else $error("prefetch limit bits 31:20 not read back");

	property p_limit_ones;
		s_wr(BWU_OFF_PF_TOP_LOW)
			##1 !(reg_wr && (reg_addr == BWU_OFF_PF_TOP_LOW))
			|=> (pf_limit_full[31:0] ==
				{$past(reg_wdata[31:20], 2), 20'hfffff});
	endproperty
	a_limit_ones: assert property (p_limit_ones)
		else $error("limit low 20 bits not all ones");

	property p_limit_upper;
		s_wr(BWU_OFF_PF_TOP_HIGH)
			##1 !(reg_wr && (reg_addr == BWU_OFF_PF_TOP_HIGH))
			|=> (pf_limit_full[63:32] == $past(reg_wdata, 2));
	endproperty
	a_limit_upper: assert property (p_limit_upper)
		else $error("upper limit word not joined into 64-bit top");

	property p_bot_high_back;
		s_wr(BWU_OFF_PF_BOT_HIGH) ##1 s_rd(BWU_OFF_PF_BOT_HIGH)
			|=> (reg_rdata == $past(reg_wdata, 2));
	endproperty
	a_bot_high_back: assert property (p_bot_high_back)
		else $error("prefetch base upper word not read back");

	property p_upper_reset;
		$fell(sys_rst) |-> (pf_bot_high == 32'h00000000)
			&& (pf_top_high == 32'h00000000);
	endproperty
	a_upper_reset: assert property (p_upper_reset)
		else $error("prefetch upper words not zero after reset");

	property p_top_high_back;
		s_wr(BWU_OFF_PF_TOP_HIGH) ##1 s_rd(BWU_OFF_PF_TOP_HIGH)
			|=> (reg_rdata == $past(reg_wdata, 2));
	endproperty
	a_top_high_back: assert property (p_top_high_back)
		else $error("prefetch limit upper word not read back");

	property p_io_reset;
		$fell(sys_rst) |-> (io_bottom_high == 16'h0000)
			&& (io_top_high == 16'h0000);
	endproperty
	a_io_reset: assert property (p_io_reset)
		else $error("I/O upper halves not zero after reset");

	property p_io_back;
		s_wr(BWU_OFF_IO_HIGH) ##1 s_rd(BWU_OFF_IO_HIGH)
			|=> (reg_rdata == $past(reg_wdata, 2))
			&& (io_top_high == reg_rdata[31:16]);
	endproperty
	a_io_back: assert property (p_io_back)
		else $error("I/O upper halves not read back in place");

	property p_cap_ptr;
		s_rd(BWU_OFF_CAP_PTR) |=> (reg_rdata == 32'h000000dc);
	endproperty
	a_cap_ptr: assert property (p_cap_ptr)
		else $error("capability pointer not DCh");

	property p_int_pin;
		s_wr(BWU_OFF_INT_PIN) ##1 s_rd(BWU_OFF_INT_PIN)
			|=> (reg_rdata[15:8] == 8'h00);
	endproperty
	a_int_pin: assert property (p_int_pin)
		else $error("interrupt pin byte not zero");

	property p_base_zero;
		!sys_rst ##1 !sys_rst |-> (pf_base_full[19:0] == 20'h00000)
			&& (pf_base_full[31:20] == $past(pf_base_low));
	endproperty
	a_base_zero: assert property (p_base_zero)
		else $error("base low 20 bits not zero or base field lost");

	property p_hit_below;
		mem_addr_valid && (mem_addr < pf_base_full)
			|=> pf_hit_valid && !pf_hit;
	endproperty
	a_hit_below: assert property (p_hit_below)
		else $error("address below base flagged as hit");

	property p_hit_edges;
		mem_addr_valid && (pf_base_full <= pf_limit_full)
			&& ((mem_addr == pf_base_full) || (mem_addr == pf_limit_full))
			|=> pf_hit_valid && pf_hit;
	endproperty
	a_hit_edges: assert property (p_hit_edges)
		else $error("window bound address not flagged as hit");

	property p_hit_above;
		mem_addr_valid && (mem_addr > pf_limit_full) |=> !pf_hit;
	endproperty
	a_hit_above: assert property (p_hit_above)
		else $error("address above limit flagged as hit");

endmodule
`default_nettype wire

// ===== rtl/bwu_win_if.sv
// Purpose: Carries window bounds and a probe address to the comparator
// Assumes: One clock domain
// Notes:   Hit and its valid come from flip-flops in the comparator
`timescale 1ns/1ns
`default_nettype none
interface bwu_win_if;
	logic [63:0] base;
	logic [63:0] limit;
	logic [63:0] addr;
	logic        req;
	logic        hit;
	logic        hit_vld;

	modport top (
		output base,
		output limit,
		output addr,
		output req,
		input  hit,
		input  hit_vld
	);
	modport cmp (
		input  base,
		input  limit,
		input  addr,
		input  req,
		output hit,
		output hit_vld
	);
endinterface
`default_nettype wire

// ===== rtl/bwu_window_cmp.sv
// Purpose: Registered 64-bit inclusive range check of a probe address
// Assumes: Bounds are already assembled to full 64-bit addresses
// Notes:   Answer one cycle after the probe
`timescale 1ns/1ns
`default_nettype none
module bwu_window_cmp
	import bwu_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	bwu_win_if.cmp    win
);

	// Both ends inclusive; a limit below the base matches nothing
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			win.hit <= 1'b0;
		end else if (win.req) begin
			win.hit <= (win.addr >= win.base) && (win.addr <= win.limit);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			win.hit_vld <= 1'b0;
		end else begin
			win.hit_vld <= win.req;
		end
	end

endmodule
`default_nettype wire

// ===== testbench/bwu_top_tb.sv
// Purpose: Self-checking bench for the bridge window upper register bank
// Assumes: Register port answers a read in the following cycle only
// Notes:   All inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ns
`default_nettype none
module bwu_top_tb;
	import bwu_pkg::*;

	logic        clk_sys;
	logic        sys_rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic [11:0] pf_base_low;
	logic [63:0] mem_addr;
	logic        mem_addr_valid;
	logic        pf_hit;
	logic        pf_hit_valid;
	logic [63:0] pf_base_full;
	logic [63:0] pf_limit_full;
	logic [15:0] io_bottom_high;
	logic [15:0] io_top_high;
	int          fails;
	int          n_checks;
	logic [63:0] pa [7];
	logic        ph [7];

	bwu_top dut_u (
		.clk_sys        (clk_sys),
		.sys_rst        (sys_rst),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.pf_base_low    (pf_base_low),
		.mem_addr       (mem_addr),
		.mem_addr_valid (mem_addr_valid),
		.pf_hit         (pf_hit),
		.pf_hit_valid   (pf_hit_valid),
		.pf_base_full   (pf_base_full),
		.pf_limit_full  (pf_limit_full),
		.io_bottom_high (io_bottom_high),
		.io_top_high    (io_top_high)
	);

	always #2 clk_sys = ~clk_sys;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		chk({32'h0, reg_rdata}, {32'h0, e});
	endtask

	// Write then read the same word with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		reg_rd    <= 1'b1;
		@(posedge clk_sys);
		reg_rd    <= 1'b0;
		#1;
		chk({32'h0, reg_rdata}, {32'h0, e});
	endtask

	// Back-to-back probes; each answer lands one cycle after its probe
	task automatic probes(input int n);
		for (int i = 0; i <= n; i++) begin
			@(posedge clk_sys);
			if (i < n) begin
				mem_addr       <= pa[i];
				mem_addr_valid <= 1'b1;
			end else begin
				mem_addr_valid <= 1'b0;
			end
			#1;
			if (i > 0) begin
				chk({63'h0, pf_hit_valid}, 64'h1);
				chk({63'h0, pf_hit}, {63'h0, ph[i-1]});
			end
		end
		@(posedge clk_sys);
		#1;
		chk({63'h0, pf_hit_valid}, 64'h0);
	endtask

	task automatic finish_test;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#40000;
		fails++;
		finish_test();
	end

	initial begin
		clk_sys        = 1'b0;
		sys_rst        = 1'b1;
		reg_addr       = 8'h00;
		reg_wdata      = 32'h0;
		reg_wr         = 1'b0;
		reg_rd         = 1'b0;
		pf_base_low    = 12'h000;
		mem_addr       = 64'h0;
		mem_addr_valid = 1'b0;
		fails          = 0;
		n_checks       = 0;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk(pf_limit_full, 64'h00000000_000fffff);
		chk(pf_base_full, 64'h0);
		rd_chk(8'h24, 32'h00010000);
		rd_chk(8'h28, 32'h0);
		rd_chk(8'h2c, 32'h0);
		rd_chk(8'h30, 32'h0);
		rd_chk(8'h34, 32'h000000dc);
		rd_chk(8'h3c, 32'h0);
		rd_chk(8'h38, 32'h0);
		// Read-only places must shrug off writes of all ones
		wr(8'h24, 32'hffffffff);
		wr(8'h34, 32'hffffffff);
		wr_rd(8'h3c, 32'hffffffff, 32'h0);
		wr(8'h38, 32'hffffffff);
		rd_chk(8'h24, 32'hfff10000);
		rd_chk(8'h34, 32'h000000dc);
		rd_chk(8'h3c, 32'h0);
		rd_chk(8'h38, 32'h0);
		wr_rd(8'h24, 32'h45600000, 32'h45610000);
		wr_rd(8'h28, 32'h00000001, 32'h00000001);
		wr_rd(8'h2c, 32'h00000001, 32'h00000001);
		wr_rd(8'h30, 32'habcd1234, 32'habcd1234);
		@(posedge clk_sys);
		pf_base_low <= 12'h123;
		rd_chk(8'h24, 32'h45610000);
		rd_chk(8'h28, 32'h00000001);
		rd_chk(8'h2c, 32'h00000001);
		rd_chk(8'h30, 32'habcd1234);
		chk({48'h0, io_bottom_high}, 64'h1234);
		chk({48'h0, io_top_high}, 64'habcd);
		chk(pf_limit_full, 64'h00000001_456fffff);
		chk(pf_base_full, 64'h00000001_12300000);
		pa[0] = 64'h00000001_122fffff; ph[0] = 1'b0;
		pa[1] = 64'h00000001_12300000; ph[1] = 1'b1;
		pa[2] = 64'h00000001_456fffff; ph[2] = 1'b1;
		pa[3] = 64'h00000001_45700000; ph[3] = 1'b0;
		pa[4] = 64'h00000000_30000000; ph[4] = 1'b0;
		pa[5] = 64'h00000002_30000000; ph[5] = 1'b0;
		pa[6] = 64'h00000001_30000000; ph[6] = 1'b1;
		probes(7);
		// Limit below base leaves an empty window
		@(posedge clk_sys);
		pf_base_low <= 12'h500;
		repeat (3) @(posedge clk_sys);
		pa[0] = 64'h00000001_50000000; ph[0] = 1'b0;
		pa[1] = 64'h00000001_456fffff; ph[1] = 1'b0;
		probes(2);
		// A second reset in mid-run must clear the writable words
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_chk(8'h24, 32'h00010000);
		rd_chk(8'h28, 32'h0);
		rd_chk(8'h2c, 32'h0);
		rd_chk(8'h30, 32'h0);
		chk({32'h0, io_top_high, io_bottom_high}, 64'h0);
		finish_test();
	end
endmodule
`default_nettype wire
